/* File: src/wis_map.svh */
`ifndef WIS_MAP_SVH
`define WIS_MAP_SVH
// ==========================================================
// Source numbering
`define WIS_NSRC        45
`define WIS_NEXT        11
`define WIS_NPERI       32
`define WIS_NSWI        4
`define WIS_SRC_W       6
`define WIS_SRC_SOFT    0
`define WIS_SRC_EXT0    1
`define WIS_SRC_EXT4    5
`define WIS_SRC_TICK    12
`define WIS_SRC_PERI0   13
// ==========================================================
// Status register layout
`define WIS_MASK_HI     15
`define WIS_MASK_LO     13
`define WIS_IE_BIT      0
`define WIS_STATUS_RST  16'h0000
// ==========================================================
// Sense encodings and levels
`define WIS_SENSE_LOW   2'h0
`define WIS_SENSE_HIGH  2'h1
`define WIS_SENSE_FALL  2'h2
`define WIS_SENSE_RISE  2'h3
`define WIS_LVL_W       3
`define WIS_LVL_OFF     3'h0
`define WIS_VEC_W       10
`define WIS_VEC_SHIFT   4
`endif

/* File: src/wis_pkg.sv */
`include "wis_map.svh"
package wis_pkg;
  // ==========================================================
  // Types
  typedef logic [1:0]               wis_sense_t;
  typedef logic [`WIS_LVL_W-1:0]    wis_level_t;
  typedef logic [`WIS_SRC_W-1:0]    wis_src_t;
  typedef logic [`WIS_VEC_W-1:0]    wis_vector_t;
  typedef enum logic {WIS_RUN, WIS_STANDBY} wis_mode_t;

  // Vector value that names one source
  function automatic wis_vector_t wis_vector(input wis_src_t src);
    wis_vector = wis_vector_t'({4'h0, src}) << `WIS_VEC_SHIFT;
  endfunction

  // True when a line is in its active state for a level mode
  function automatic logic wis_level_on(input wis_sense_t s, input logic now);
    wis_level_on = (s == `WIS_SENSE_LOW) ? ~now : now;
  endfunction
endpackage

/* File: src/wis_irq_if.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
interface wis_irq_if;
  import wis_pkg::*;
  logic [`WIS_NSRC-1:0] raw;
  wis_sense_t           sense [`WIS_NSRC];
  logic [`WIS_NSRC-1:0] clear;
  logic [`WIS_NSRC-1:0] pending;
  logic [`WIS_NSRC-1:0] event_hit;
  wis_level_t           level [`WIS_NSRC];
  logic                 win_valid;
  wis_src_t             win_src;
  wis_level_t           win_level;

  modport sense_mp (input raw, sense, clear, output pending, event_hit);
  modport prio_mp  (input pending, level, output win_valid, win_src, win_level);
endinterface

/* File: src/wis_sense.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
module wis_sense (
  input  wire logic    ref_clk,
  input  wire logic    reset,
  wis_irq_if.sense_mp  irq
);
  import wis_pkg::*;

  // ==========================================================
  // One detector per source
  genvar i;
  generate
    for (i = 0; i < `WIS_NSRC; i++) begin : g_src
      logic prev_reg;
      logic flag_reg;
      logic is_edge;
      logic hit;

      assign is_edge = irq.sense[i][1];
      // Edge modes match the transition, level modes the entry into the active state
      assign hit = is_edge ?
                   ((irq.sense[i] == `WIS_SENSE_RISE) ? (irq.raw[i] & ~prev_reg)
                                                      : (~irq.raw[i] & prev_reg))
                 : (wis_level_on(irq.sense[i], irq.raw[i]) &
                    ~wis_level_on(irq.sense[i], prev_reg));

      // Previous line state for edge detection
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= irq.raw[i];
        end
      end

      // Sticky edge flag; a new edge beats a clear in the same cycle
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= (is_edge & hit) | (flag_reg & ~irq.clear[i]);
        end
      end

      // Level requests are live, so a line dropped early is simply gone
      assign irq.pending[i]   = is_edge ? flag_reg : wis_level_on(irq.sense[i], irq.raw[i]);
      assign irq.event_hit[i] = hit;
    end
  endgenerate
endmodule

/* File: src/wis_prio.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
module wis_prio (
  wis_irq_if.prio_mp  irq
);
  import wis_pkg::*;

  // ==========================================================
  // Highest level wins; on a tie the lower source number wins
  always_comb begin
    wis_level_t best_lvl;
    wis_src_t   best_src;
    best_lvl = `WIS_LVL_OFF;
    best_src = '0;
    for (int i = 0; i < `WIS_NSRC; i++) begin
      if (irq.pending[i] && (irq.level[i] > best_lvl)) begin
        best_lvl = irq.level[i];
        best_src = wis_src_t'(i);
      end
    end
    irq.win_level = best_lvl;
    irq.win_src   = best_src;
    irq.win_valid = (best_lvl != `WIS_LVL_OFF);
  end
endmodule

/* File: src/wis_top.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
module wis_top (
  input  wire logic                             ref_clk,
  input  wire logic                             reset,
  // External and internal request lines
  input  wire logic                             nmi_pin_n,
  input  wire logic [`WIS_NEXT-1:0]             ext_irq_pins,
  input  wire logic                             clock_tick_irq,
  input  wire logic [`WIS_NPERI-1:0]            periph_irq,
  // Controller per-source settings
  input  wire wis_pkg::wis_sense_t              irq_sense_field [`WIS_NSRC],
  input  wire wis_pkg::wis_level_t              irq_priority_level [`WIS_NSRC],
  input  wire logic [`WIS_NSRC-1:0]             irq_clear,
  // Clock generator wake settings, index 0..4 ext sources, 5 clock tick
  input  wire logic [5:0]                       wake_source_enable,
  input  wire wis_pkg::wis_sense_t              wake_polarity_field [6],
  input  wire logic                             standby_req,
  // Status register access
  input  wire logic                             status_wr,
  input  wire logic [15:0]                      status_wdata,
  // Core handshake
  input  wire logic                             irq_ack,
  input  wire logic                             nmi_ack,
  input  wire logic [`WIS_NSWI-1:0]             sw_int_set,
  input  wire logic [`WIS_NSWI-1:0]             sw_int_clear,
  // DMA trigger selection
  input  wire logic                             dma_trig_en,
  input  wire wis_pkg::wis_src_t                dma_trig_sel,
  // Outputs
  output logic [15:0]                           status_reg,
  output logic [2:0]                            mask_level_field,
  output logic                                  irq_global_enable,
  output logic                                  hw_irq_req,
  output logic                                  sw_irq_req,
  output logic                                  nmi_req,
  output wis_pkg::wis_level_t                   irq_level_out,
  output wis_pkg::wis_src_t                     irq_src_out,
  output wis_pkg::wis_vector_t                  irq_vector_out,
  output logic [`WIS_NSWI-1:0]                  sw_pending_out,
  output logic [`WIS_NSRC-1:0]                  pending_out,
  output logic                                  dma_trigger,
  output logic                                  standby_active,
  output logic                                  wake_pulse,
  output logic                                  wake_isr
);
  import wis_pkg::*;

  // ==========================================================
  // Internal carrier and state
  wis_irq_if irq ();

  wis_mode_t              mode_reg;
  wis_mode_t              mode_next;
  logic [15:0]            status_next;
  wis_level_t             lvl_reg;
  wis_src_t               src_reg;
  wis_vector_t            vec_reg;
  logic                   valid_reg;
  logic [`WIS_NSWI-1:0]   sw_pend_reg;
  logic                   nmi_prev_reg;
  logic                   nmi_pend_reg;
  logic                   dma_reg;
  logic                   wake_pulse_reg;
  logic                   wake_isr_reg;
  logic [`WIS_NSRC-1:0]   pend_reg;
  logic [`WIS_NSRC-1:0]   wake_sel;
  logic [`WIS_NSRC-1:0]   ack_clear;
  logic                   wake_any;
  logic                   wake_isr_any;
  logic                   nmi_fall;

  // ==========================================================
  // Request line assembly
  // Software-set source asserts as a high level whenever its priority is nonzero
  assign irq.raw[`WIS_SRC_SOFT] = (irq_priority_level[`WIS_SRC_SOFT] != `WIS_LVL_OFF);
  assign irq.raw[`WIS_SRC_EXT0 +: `WIS_NEXT]   = ext_irq_pins;
  assign irq.raw[`WIS_SRC_TICK]                = clock_tick_irq;
  assign irq.raw[`WIS_SRC_PERI0 +: `WIS_NPERI] = periph_irq;

  // ==========================================================
  // Effective sense and wake selection per source
  genvar g;
  generate
    for (g = 0; g < `WIS_NSRC; g++) begin : g_cfg
      if ((g >= `WIS_SRC_EXT0 && g <= `WIS_SRC_EXT4) || g == `WIS_SRC_TICK) begin : g_wake
        localparam int WI = (g == `WIS_SRC_TICK) ? 5 : g - `WIS_SRC_EXT0;
        // Wake enable hands sensing to the wake polarity field; tick expects rise here
        assign irq.sense[g] = wake_source_enable[WI] ? wake_polarity_field[WI]
                                                      : irq_sense_field[g];
        assign wake_sel[g]  = wake_source_enable[WI];
      end else if (g == `WIS_SRC_SOFT) begin : g_soft
        assign irq.sense[g] = `WIS_SENSE_HIGH;
        assign wake_sel[g]  = 1'b0;
      end else begin : g_plain
        // Controller-only sources cannot end standby
        assign irq.sense[g] = irq_sense_field[g];
        assign wake_sel[g]  = 1'b0;
      end
      assign irq.level[g] = irq_priority_level[g];
      // Acknowledge drops only the request that the core saw
      assign ack_clear[g] = irq_ack & valid_reg & (src_reg == wis_src_t'(g));
    end
  endgenerate

  assign irq.clear = irq_clear | ack_clear;

  // ==========================================================
  // Detection and ranking
  wis_sense u_sense (
    .ref_clk (ref_clk),
    .reset   (reset),
    .irq     (irq)
  );

  wis_prio u_prio (
    .irq (irq)
  );

  // ==========================================================
  // Status register: only the mask field and the enable bit are kept
  always_comb begin
    status_next = status_reg;
    if (status_wr) begin
      status_next = '0;
      status_next[`WIS_MASK_HI:`WIS_MASK_LO] = status_wdata[`WIS_MASK_HI:`WIS_MASK_LO];
      status_next[`WIS_IE_BIT] = status_wdata[`WIS_IE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= `WIS_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  assign mask_level_field  = status_reg[`WIS_MASK_HI:`WIS_MASK_LO];
  assign irq_global_enable = status_reg[`WIS_IE_BIT];

  // ==========================================================
  // Presented request, held in flops so level, source and vector agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      valid_reg <= 1'b0;
      lvl_reg   <= `WIS_LVL_OFF;
      src_reg   <= '0;
      vec_reg   <= '0;
    end else begin
      valid_reg <= irq.win_valid & ~(irq_ack & valid_reg & (irq.win_src == src_reg));
      lvl_reg   <= irq.win_level;
      src_reg   <= irq.win_src;
      vec_reg   <= wis_vector(irq.win_src);
    end
  end

  // Acceptance gate seen by the core
  assign hw_irq_req     = valid_reg & irq_global_enable & (lvl_reg > mask_level_field);
  assign irq_level_out  = lvl_reg;
  assign irq_src_out    = src_reg;
  assign irq_vector_out = vec_reg;

  // ==========================================================
  // Software interrupts, separate from the controller path
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_pend_reg <= '0;
    end else begin
      sw_pend_reg <= sw_int_set | (sw_pend_reg & ~sw_int_clear);
    end
  end

  assign sw_irq_req     = irq_global_enable & (|sw_pend_reg);
  assign sw_pending_out = sw_pend_reg;

  // ==========================================================
  // Nonmaskable pin: falling edge latched until the core acknowledges
  assign nmi_fall = ~nmi_pin_n & nmi_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nmi_prev_reg <= 1'b1;
    end else begin
      nmi_prev_reg <= nmi_pin_n;
    end
  end

  // A new edge wins over an acknowledge in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_pend_reg <= nmi_fall | (nmi_pend_reg & ~nmi_ack);
    end
  end

  assign nmi_req = nmi_pend_reg;

  // ==========================================================
  // DMA trigger: one-cycle pulse on a detected event of the chosen source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dma_reg <= 1'b0;
    end else begin
      // Out-of-range selections never fire
      dma_reg <= dma_trig_en && (dma_trig_sel < `WIS_SRC_W'(`WIS_NSRC)) &&
                 irq.event_hit[dma_trig_sel];
    end
  end

  assign dma_trigger = dma_reg;

  // ==========================================================
  // Standby and wake-up
  // Level sources wake while held; edge sources wake on the detected edge or their latched flag
  assign wake_any = |(wake_sel & (irq.event_hit | irq.pending));

  // Service routine follows only if a waking source outranks the mask
  always_comb begin
    wake_isr_any = 1'b0;
    for (int i = 0; i < `WIS_NSRC; i++) begin
      if (wake_sel[i] && (irq.event_hit[i] || irq.pending[i]) &&
          (irq_priority_level[i] > mask_level_field)) begin
        wake_isr_any = irq_global_enable;
      end
    end
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      WIS_RUN: begin
        if (standby_req) begin
          mode_next = WIS_STANDBY;
        end
      end
      WIS_STANDBY: begin
        if (wake_any) begin
          mode_next = WIS_RUN;
        end
      end
      default: begin
        mode_next = WIS_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= WIS_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Wake report towards the clock generator
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_pulse_reg <= 1'b0;
      wake_isr_reg   <= 1'b0;
    end else begin
      wake_pulse_reg <= (mode_reg == WIS_STANDBY) & wake_any;
      if ((mode_reg == WIS_STANDBY) && wake_any) begin
        wake_isr_reg <= wake_isr_any;
      end
    end
  end

  assign standby_active = (mode_reg == WIS_STANDBY);
  assign wake_pulse     = wake_pulse_reg;
  assign wake_isr       = wake_isr_reg;

  // ==========================================================
  // Pending snapshot for software
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= irq.pending;
    end
  end

  assign pending_out = pend_reg;
endmodule

/* File: bench/wis_props.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
// ==========================================================
// Port checker for the sensing top
module wis_props (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire logic                 status_wr,
  input wire logic [15:0]          status_wdata,
  input wire logic [15:0]          status_reg,
  input wire logic [2:0]           mask_level_field,
  input wire logic                 irq_global_enable,
  input wire logic                 hw_irq_req,
  input wire logic                 irq_ack,
  input wire wis_pkg::wis_level_t  irq_level_out,
  input wire wis_pkg::wis_src_t    irq_src_out,
  input wire wis_pkg::wis_vector_t irq_vector_out,
  input wire logic                 nmi_pin_n,
  input wire logic                 nmi_req,
  input wire logic [3:0]           sw_int_set,
  input wire logic [3:0]           sw_pending_out,
  input wire logic                 standby_req,
  input wire logic                 standby_active,
  input wire logic                 wake_pulse,
  input wire logic                 dma_trigger
);
  import wis_pkg::*;
  // All checks share the one clock and its reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_mask_view: assert property (
    mask_level_field == status_reg[15:13] && irq_global_enable == status_reg[0])
    else $error("mask or enable view wrong");
  a_status_write: assert property (
    status_wr |=> status_reg == ($past(status_wdata) & 16'he001))
    else $error("status write not stored");
  a_req_gate: assert property (
    hw_irq_req |-> irq_global_enable && irq_level_out > mask_level_field)
    else $error("request shown while gated");
  a_vector_code: assert property (
    hw_irq_req |-> irq_vector_out == {irq_src_out, 4'h0})
    else $error("vector does not match source");
  a_ack_drop: assert property (
    hw_irq_req && irq_ack |=> !hw_irq_req)
    else $error("request stayed after ack");
  a_nmi_catch: assert property (
    $fell(nmi_pin_n) |=> nmi_req)
    else $error("nmi edge missed");
  a_sw_post: assert property (
    |sw_int_set |=> (sw_pending_out & $past(sw_int_set)) == $past(sw_int_set))
    else $error("software bit not posted");
  a_standby_in: assert property (
    standby_req && !standby_active |=> standby_active)
    else $error("standby not entered");
  a_wake_exit: assert property (
    $fell(standby_active) |-> wake_pulse)
    else $error("left standby without wake pulse");

  c_ack: cover property (hw_irq_req && irq_ack);
  c_wake: cover property (wake_pulse);
  c_dma: cover property (dma_trigger);
endmodule

bind wis_top wis_props u_props (
  .ref_clk, .reset, .status_wr, .status_wdata, .status_reg, .mask_level_field,
  .irq_global_enable, .hw_irq_req, .irq_ack, .irq_level_out, .irq_src_out,
  .irq_vector_out, .nmi_pin_n, .nmi_req, .sw_int_set, .sw_pending_out,
  .standby_req, .standby_active, .wake_pulse, .dma_trigger
);

/* File: bench/wis_core_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Core side: takes presented requests after a set delay
module wis_core_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       hw_irq_req,
  input  wire logic       nmi_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack,
  output logic            nmi_ack
);
  logic [3:0] wait_reg;

  // A slow core leaves the winner standing so the bench can look at it
  always_ff @(posedge ref_clk) begin
    if (reset || irq_ack) begin
      irq_ack  <= 1'b0;
      wait_reg <= 4'h0;
    end else if (hw_irq_req && ack_en) begin
      irq_ack  <= (wait_reg >= ack_delay);
      wait_reg <= wait_reg + 4'h1;
    end else begin
      wait_reg <= 4'h0;
    end
  end

  // Nonmaskable requests are taken at once
  always_ff @(posedge ref_clk) begin
    nmi_ack <= !reset && nmi_req && !nmi_ack;
  end
endmodule

/* File: bench/tb_wis_top.sv */
`timescale 1ns/1ps
`include "wis_map.svh"
module tb_wis_top;
  import wis_pkg::*;
  logic                 ref_clk, reset, nmi_pin_n, status_wr, standby_req, dma_trig_en;
  logic                 ack_en, irq_ack, nmi_ack, hw_irq_req, sw_irq_req, nmi_req, clock_tick_irq;
  logic                 irq_global_enable, dma_trigger, standby_active, wake_pulse, wake_isr;
  logic [10:0]          ext_irq_pins;
  logic [31:0]          periph_irq;
  logic [44:0]          irq_clear, pending_out;
  logic [5:0]           wake_source_enable;
  logic [3:0]           sw_int_set, sw_int_clear, sw_pending_out;
  logic [15:0]          status_wdata, status_reg;
  logic [2:0]           mask_level_field;
  wis_sense_t           irq_sense_field [`WIS_NSRC], wake_polarity_field [6];
  wis_level_t           irq_priority_level [`WIS_NSRC], irq_level_out;
  wis_src_t             dma_trig_sel, irq_src_out;
  wis_vector_t          irq_vector_out;
  int                   miscompares, compares, i;
  wis_src_t             exp_src [3] = '{6'd10, 6'd7, 6'd13};
  wis_level_t           exp_lvl [3] = '{3'h6, 3'h5, 3'h2};

  wis_top dut (
    .ref_clk, .reset, .nmi_pin_n, .ext_irq_pins, .clock_tick_irq, .periph_irq,
    .irq_sense_field, .irq_priority_level, .irq_clear, .wake_source_enable,
    .wake_polarity_field, .standby_req, .status_wr, .status_wdata, .irq_ack, .nmi_ack,
    .sw_int_set, .sw_int_clear, .dma_trig_en, .dma_trig_sel, .status_reg,
    .mask_level_field, .irq_global_enable, .hw_irq_req, .sw_irq_req, .nmi_req,
    .irq_level_out, .irq_src_out, .irq_vector_out, .sw_pending_out, .pending_out,
    .dma_trigger, .standby_active, .wake_pulse, .wake_isr
  );
  wis_core_model core (
    .ref_clk, .reset, .hw_irq_req, .nmi_req, .ack_en, .ack_delay(4'h4), .irq_ack, .nmi_ack
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Helpers
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Looks just after the edge so that edge's updates have landed
  task look(input int n);
    cyc(n);
    #1;
  endtask
  task chk(input logic [44:0] got, input logic [44:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task complete_run;
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task bound(input int n, input int lim);
    compares++;
    if (n >= lim) begin
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      complete_run();
    end
  endtask
  task wr_status(input logic [15:0] v);
    cyc(1);
    status_wr    <= 1'b1;
    status_wdata <= v;
    cyc(1);
    status_wr    <= 1'b0;
  endtask
  task clr(input int s);
    cyc(1);
    irq_clear[s] <= 1'b1;
    cyc(1);
    irq_clear[s] <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    nmi_pin_n = 1'b1;
    {status_wr, standby_req, dma_trig_en, ack_en, clock_tick_irq} = 5'h00;
    {ext_irq_pins, periph_irq, irq_clear, wake_source_enable} = '0;
    {sw_int_set, sw_int_clear, status_wdata, dma_trig_sel} = '0;
    miscompares = 0;
    compares = 0;
    for (i = 0; i < `WIS_NSRC; i++) begin
      irq_sense_field[i] = `WIS_SENSE_RISE;
      irq_priority_level[i] = `WIS_LVL_OFF;
    end
    for (i = 0; i < 6; i++) wake_polarity_field[i] = `WIS_SENSE_RISE;
    cyc(6);
    reset <= 1'b0;
    look(1);
    chk(status_reg, 16'h0000, "status reset");
    chk(pending_out, 45'h0, "pending reset");
    $display("test reset done");
    wr_status(16'hffff);
    look(1);
    chk(status_reg, 16'he001, "status bits");
    chk(mask_level_field, 3'h7, "mask field");
    wr_status(16'h6001);
    $display("test status done");
    // Every sense code on one plain pin: idle, then active
    for (int c = 0; c < 4; c++) begin
      cyc(1);
      irq_priority_level[6] <= 3'h1;
      irq_sense_field[6] <= wis_sense_t'(c);
      ext_irq_pins[5] <= (c == 0 || c == 2);
      look(2);
      clr(6);
      look(2);
      chk(pending_out[6], 1'b0, "idle pending");
      cyc(1);
      ext_irq_pins[5] <= (c == 1 || c == 3);
      look(3);
      chk(pending_out[6], 1'b1, "active missed");
      cyc(1);
      ext_irq_pins[5] <= (c == 0 || c == 2);
      clr(6);
    end
    $display("test sense done");
    // Four at once, one tie, one below the mask
    cyc(1);
    irq_priority_level[7] <= 3'h5;
    irq_priority_level[9] <= 3'h6;
    irq_priority_level[10] <= 3'h6;
    irq_priority_level[13] <= 3'h2;
    cyc(2);
    ext_irq_pins[6] <= 1'b1;
    ext_irq_pins[8] <= 1'b1;
    ext_irq_pins[9] <= 1'b1;
    periph_irq[0] <= 1'b1;
    look(3);
    chk(irq_src_out, 6'd9, "winner");
    chk(irq_level_out, 3'h6, "level");
    chk(irq_vector_out, 10'h090, "vector");
    cyc(1);
    ack_en <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      for (i = 0; i < 40 && irq_src_out !== exp_src[k]; i++) look(1);
      bound(i, 40);
      look(1);
      chk(irq_level_out, exp_lvl[k], "next level");
      chk(irq_vector_out, {exp_src[k], 4'h0}, "next vector");
      chk(hw_irq_req, k < 2, "mask gate");
    end
    clr(13);
    $display("test priority done");
    cyc(1);
    dma_trig_en <= 1'b1;
    dma_trig_sel <= 6'd8;
    cyc(2);
    ext_irq_pins[7] <= 1'b1;
    for (i = 0; i < 6 && dma_trigger !== 1'b1; i++) look(1);
    bound(i, 6);
    look(1);
    chk(dma_trigger, 1'b0, "dma pulse");
    cyc(1);
    sw_int_set <= 4'h5;
    cyc(1);
    sw_int_set <= 4'h0;
    look(1);
    chk(sw_pending_out, 4'h5, "software set");
    chk(sw_irq_req, 1'b1, "software req");
    cyc(1);
    sw_int_clear <= 4'hf;
    cyc(1);
    sw_int_clear <= 4'h0;
    look(1);
    chk(sw_pending_out, 4'h0, "software clear");
    cyc(1);
    nmi_pin_n <= 1'b0;
    for (i = 0; i < 4 && nmi_req !== 1'b1; i++) look(1);
    bound(i, 4);
    for (i = 0; i < 10 && nmi_req !== 1'b0; i++) look(1);
    bound(i, 10);
    $display("test dma software nmi done");
    // Wake source on falling edge; controller sense set high and ignored
    cyc(1);
    wake_source_enable <= 6'h01;
    wake_polarity_field[0] <= `WIS_SENSE_FALL;
    irq_sense_field[1] <= `WIS_SENSE_HIGH;
    irq_priority_level[1] <= 3'h5;
    irq_priority_level[2] <= 3'h6;
    ext_irq_pins[0] <= 1'b1;
    look(3);
    chk(pending_out[1], 1'b0, "wake sense");
    cyc(1);
    standby_req <= 1'b1;
    cyc(1);
    standby_req <= 1'b0;
    look(1);
    chk(standby_active, 1'b1, "standby");
    cyc(1);
    ext_irq_pins[1] <= 1'b1;
    look(3);
    chk(standby_active, 1'b1, "woken by plain pin");
    chk(pending_out[2], 1'b1, "plain pin sense");
    cyc(1);
    ext_irq_pins[0] <= 1'b0;
    for (i = 0; i < 6 && wake_pulse !== 1'b1; i++) look(1);
    bound(i, 6);
    chk(wake_isr, 1'b1, "wake service");
    chk(standby_active, 1'b0, "still standby");
    // Clock tick wakes on its rising edge; priority zero means no service routine
    cyc(1);
    wake_source_enable <= 6'h20;
    irq_sense_field[12] <= `WIS_SENSE_HIGH;
    cyc(1);
    standby_req <= 1'b1;
    cyc(1);
    standby_req <= 1'b0;
    look(1);
    chk(standby_active, 1'b1, "tick standby");
    cyc(1);
    clock_tick_irq <= 1'b1;
    for (i = 0; i < 6 && wake_pulse !== 1'b1; i++) look(1);
    bound(i, 6);
    chk(wake_isr, 1'b0, "tick wake service");
    chk(standby_active, 1'b0, "tick still standby");
    $display("test wake done");
    complete_run();
  end
endmodule
